// ### afe_current_temp_balance_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_params.svh"

module afe_current_temp_balance_control
    import afe_ctrl_pkg::*;
#(
    parameter int BAL_WIDTH = `BAL_W
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 overcurrentTrip,
    output logic                      senseSelect,
    output logic [3:0]                ampGain,
    output logic [1:0]                zeroLevelNum,
    output logic [2:0]                zeroLevelDen,
    output logic                      ampInverting,
    output logic [`CFG_THR_W-1:0]     overcurrentThreshold,
    output logic                      comparatorPolarity,
    output logic                      alertOut,
    output logic                      alertOe_b,
    input  wire logic                 alertIn,
    output logic                      thermistorBiasEnable,
    output logic [`CELL_OSEL_W-1:0]   cellOutputSelect,
    output logic [`CELL_SEL_W-1:0]    cellIndex,
    output logic                      tempToCellOut,
    output logic [BAL_WIDTH-1:0]      balanceSwitchOn,
    output logic                      irq
);
    // Reset leaves the alert synchroniser at the pulled-up idle level of the pin.
    // Starting it low would report a false rising edge on the first clocks after reset.
    localparam regs_s RESET_STATE = '{
        balanceCtl: 6'h00,
        cfgReg:     8'h00,
        cellCtl:    6'h00,
        powerCtl:   8'h00,
        irqStatus:  2'h0,
        irqMask:    2'h0,
        alertSync1: 1'b1,
        alertSync2: 1'b1,
        alertPrev:  1'b1,
        prdata:     32'h00000000
    };

    regs_s        r;
    regs_s        rNxt;
    logic         known;
    logic         writable;
    logic         setupPhase;
    logic         accessPhase;
    logic         wrEn;
    logic         rdEn;
    logic         alertLevel;
    logic [1:0]   alertEvents;
    logic [31:0]  readWord;

    // True for every address that holds a register, read-only ones included.
    function automatic logic isMapped(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            `ADDR_STATUS: begin
                hit = 1'b1;
            end
            `ADDR_CELL_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_BALANCE_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_CONFIG: begin
                hit = 1'b1;
            end
            `ADDR_POWER_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_IRQ_STATUS: begin
                hit = 1'b1;
            end
            `ADDR_IRQ_MASK: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // True for the registers software may change; status is read only.
    function automatic logic isWritable(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            `ADDR_CELL_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_BALANCE_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_CONFIG: begin
                hit = 1'b1;
            end
            `ADDR_POWER_CONTROL_REG: begin
                hit = 1'b1;
            end
            `ADDR_IRQ_STATUS: begin
                hit = 1'b1;
            end
            `ADDR_IRQ_MASK: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    function automatic logic [31:0] readSelect(
        input logic [11:0] a,
        input regs_s       s,
        input logic        alert
    );
        logic [31:0] word;
        word = 32'h00000000;
        case (a)
            `ADDR_STATUS: begin
                word[`STATUS_ALERT_BIT] = alert;
            end
            `ADDR_CELL_CONTROL_REG: begin
                word[5:0] = s.cellCtl;
            end
            `ADDR_BALANCE_CONTROL_REG: begin
                word[5:0] = s.balanceCtl;
            end
            `ADDR_CONFIG: begin
                word[7:0] = s.cfgReg;
            end
            `ADDR_POWER_CONTROL_REG: begin
                word[7:0] = s.powerCtl;
            end
            `ADDR_IRQ_STATUS: begin
                word[1:0] = s.irqStatus;
            end
            `ADDR_IRQ_MASK: begin
                word[1:0] = s.irqMask;
            end
            default: begin
                word = 32'h00000000;
            end
        endcase
        return word;
    endfunction

    function automatic logic [1:0] edgeEvents(
        input logic level,
        input logic prev
    );
        logic [1:0] ev;
        ev = 2'h0;
        ev[`IRQ_RISE_BIT] = level && !prev;
        ev[`IRQ_FALL_BIT] = !level && prev;
        return ev;
    endfunction

    // Write one to clear: bits written as zero are left alone.
    function automatic logic [1:0] clearOnWrite(
        input logic [1:0] status,
        input logic [1:0] ones
    );
        logic [1:0] kept;
        kept = status & ~ones;
        return kept;
    endfunction

    function automatic logic pendingIrq(
        input logic [1:0] status,
        input logic [1:0] mask
    );
        logic any;
        any = |(status & mask);
        return any;
    endfunction

    function automatic logic [3:0] gainFor(input logic highGain);
        logic [3:0] g;
        if (highGain) begin
            g = `GAIN_HIGH;
        end else begin
            g = `GAIN_LOW;
        end
        return g;
    endfunction

    function automatic sense_sel_e pinFor(input logic positive);
        sense_sel_e p;
        if (positive) begin
            p = SENSE_POS;
        end else begin
            p = SENSE_NEG;
        end
        return p;
    endfunction

    function automatic logic [`CFG_THR_W-1:0] thresholdOf(input logic [7:0] cfg);
        logic [`CFG_THR_W-1:0] f;
        f = cfg[`CFG_THR_LSB +: `CFG_THR_W];
        return f;
    endfunction

    function automatic logic [`CELL_OSEL_W-1:0] cellOsel(input logic [5:0] ctl);
        logic [`CELL_OSEL_W-1:0] f;
        f = ctl[`CELL_OSEL_LSB +: `CELL_OSEL_W];
        return f;
    endfunction

    function automatic logic [`CELL_SEL_W-1:0] cellIdx(input logic [5:0] ctl);
        logic [`CELL_SEL_W-1:0] f;
        f = ctl[`CELL_SEL_LSB +: `CELL_SEL_W];
        return f;
    endfunction

    function automatic logic isTempSelect(
        input logic [`CELL_OSEL_W-1:0] osel,
        input logic [`CELL_SEL_W-1:0]  idx
    );
        logic hit;
        hit = (osel == `OSEL_TEMP) && (idx == `CELL_IDX_TEMP);
        return hit;
    endfunction

    assign known       = isMapped(paddr);
    assign writable    = isWritable(paddr);
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrEn        = accessPhase && pwrite && writable;
    assign rdEn        = setupPhase && !pwrite;
    assign alertLevel  = r.alertSync2;
    assign alertEvents = edgeEvents(r.alertSync2, r.alertPrev);
    assign readWord    = readSelect(paddr, r, alertLevel);

    always_comb begin
        rNxt = r;
        // Only the second flop feeds logic; the first may still be settling.
        rNxt.alertSync1 = alertIn;
        rNxt.alertSync2 = r.alertSync1;
        rNxt.alertPrev  = r.alertSync2;
        if (wrEn) begin
            case (paddr)
                `ADDR_CELL_CONTROL_REG: begin
                    rNxt.cellCtl = pwdata[5:0];
                end
                `ADDR_BALANCE_CONTROL_REG: begin
                    rNxt.balanceCtl = pwdata[5:0];
                end
                `ADDR_CONFIG: begin
                    rNxt.cfgReg = pwdata[7:0];
                end
                `ADDR_POWER_CONTROL_REG: begin
                    rNxt.powerCtl = pwdata[7:0];
                end
                `ADDR_IRQ_STATUS: begin
                    rNxt.irqStatus = clearOnWrite(r.irqStatus, pwdata[1:0]);
                end
                `ADDR_IRQ_MASK: begin
                    rNxt.irqMask = pwdata[1:0];
                end
                default: begin
                    rNxt.irqMask = r.irqMask;
                end
            endcase
        end
        // Set after clear, so an event in the cycle of its own clear is not lost.
        rNxt.irqStatus = rNxt.irqStatus | alertEvents;
        // Read data is loaded in the setup cycle, so it stands through the access cycle.
        if (rdEn) begin
            rNxt.prdata = readWord;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= RESET_STATE;
        end else begin
            r <= rNxt;
        end
    end

    // No wait states: every transfer completes in its first access cycle.
    assign prdata  = r.prdata;
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !known;

    assign senseSelect  = pinFor(r.cfgReg[`CFG_SENSE_BIT]);
    assign ampGain      = gainFor(r.cfgReg[`CFG_GAIN_BIT]);
    assign zeroLevelNum = `ZERO_LEVEL_NUM;
    assign zeroLevelDen = `ZERO_LEVEL_DEN;
    assign ampInverting = 1'b1;

    // Code 0 is the lowest trip level, full scale the highest; the analog side maps the steps.
    assign overcurrentThreshold = thresholdOf(r.cfgReg);
    assign comparatorPolarity   = r.cfgReg[`CFG_POL_BIT];

    // Open drain: the pin is only ever pulled low, and only while the comparator trips.
    // The trip is passed straight through so the alert reaches the host without delay.
    assign alertOut  = 1'b0;
    assign alertOe_b = !overcurrentTrip;

    assign thermistorBiasEnable = r.powerCtl[`PWR_TB_BIT];
    assign cellOutputSelect     = cellOsel(r.cellCtl);
    assign cellIndex            = cellIdx(r.cellCtl);
    assign tempToCellOut        = isTempSelect(cellOutputSelect, cellIndex);
    assign irq                  = pendingIrq(r.irqStatus, r.irqMask);

    // The interlock is combinational on the register, so it follows every write at once.
    balance_interlock #(
        .WIDTH (BAL_WIDTH)
    ) u_interlock (
        .request  (r.balanceCtl[BAL_WIDTH-1:0]),
        .switchOn (balanceSwitchOn)
    );
endmodule

`default_nettype wire

// ### afe_ctrl_params.svh
`ifndef AFE_CTRL_PARAMS_SVH
`define AFE_CTRL_PARAMS_SVH

// Byte addresses of the APB registers.
`define ADDR_STATUS       12'h000
`define ADDR_CELL_CONTROL_REG     12'h004
`define ADDR_BALANCE_CONTROL_REG      12'h008
`define ADDR_CONFIG       12'h00C
`define ADDR_POWER_CONTROL_REG    12'h010
`define ADDR_IRQ_STATUS   12'h014
`define ADDR_IRQ_MASK     12'h018

// Config register fields.
`define CFG_GAIN_BIT      0
`define CFG_SENSE_BIT     2
`define CFG_POL_BIT       3
`define CFG_THR_LSB       4
`define CFG_THR_W         4

// Cell control fields.
`define CELL_SEL_LSB      0
`define CELL_SEL_W        3
`define CELL_OSEL_LSB     4
`define CELL_OSEL_W       2
`define OSEL_TEMP         2'h1
`define CELL_IDX_TEMP     3'h6

// Status register fields.
`define STATUS_ALERT_BIT  2

// Power control fields.
`define PWR_TB_BIT        2

// Interrupt status bits.
`define IRQ_RISE_BIT      0
`define IRQ_FALL_BIT      1

`define BAL_W             6
`define GAIN_LOW          4'h4
`define GAIN_HIGH         4'h8
`define ZERO_LEVEL_NUM    2'h3
`define ZERO_LEVEL_DEN    3'h4
`define THR_MIN_MV        25
`define THR_MAX_MV        400

`endif

// ### afe_ctrl_pkg.sv
package afe_ctrl_pkg;
    typedef enum logic {
        SENSE_NEG,
        SENSE_POS
    } sense_sel_e;

    typedef struct packed {
        logic [5:0] balanceCtl;
        logic [7:0] cfgReg;
        logic [5:0] cellCtl;
        logic [7:0] powerCtl;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic       alertSync1;
        logic       alertSync2;
        logic       alertPrev;
        logic [31:0] prdata;
    } regs_s;
endpackage

// ### balance_interlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_params.svh"

// Clears every requested balance switch that has a requested neighbour.
module balance_interlock #(
    parameter int WIDTH = `BAL_W
) (
    input  wire logic [WIDTH-1:0] request,
    output logic      [WIDTH-1:0] switchOn
);
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            switchOn[i] = request[i]
                & !(i > 0 && request[(i > 0) ? i - 1 : 0])
                & !(i < WIDTH - 1 && request[(i < WIDTH - 1) ? i + 1 : i]);
        end
    end
endmodule

`default_nettype wire

// ### alert_pullup.sv
`timescale 1ns/1ps
`default_nettype none
// The alert line is open drain with a pull-up, so it reads high whenever nobody pulls it low.
module alert_pullup (
    input  wire logic alertOut,
    input  wire logic alertOe_b,
    output logic      alertIn
);
    assign alertIn = alertOe_b ? 1'b1 : alertOut;
endmodule
`default_nettype wire

// ### afe_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_params.svh"
module afe_ctrl_props (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        alertIn,
    input wire logic        overcurrentTrip,
    input wire logic        senseSelect,
    input wire logic [3:0]  ampGain,
    input wire logic [3:0]  overcurrentThreshold,
    input wire logic        comparatorPolarity,
    input wire logic        alertOe_b,
    input wire logic        thermistorBiasEnable,
    input wire logic [1:0]  cellOutputSelect,
    input wire logic [2:0]  cellIndex,
    input wire logic        tempToCellOut,
    input wire logic [5:0]  balanceSwitchOn
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence wrAt(a); psel && penable && pwrite && paddr == a; endsequence
    sequence rdAt(a); psel && !penable && !pwrite && paddr == a; endsequence
    function automatic logic wrHit(logic [11:0] a);
        return psel && penable && pwrite && paddr == a;
    endfunction
    function automatic logic [5:0] lock(logic [5:0] b); return b & ~(b << 1) & ~(b >> 1); endfunction
    chk_gain_sel: assert property (wrAt(`ADDR_CONFIG) |=> ampGain == ($past(pwdata[0]) ? `GAIN_HIGH : `GAIN_LOW))
        else $error("gain select not applied");
    chk_gain_hold: assert property (!wrHit(`ADDR_CONFIG) |=> $stable(ampGain))
        else $error("gain changed without write");
    chk_cfg_fields: assert property (wrAt(`ADDR_CONFIG) |=> {overcurrentThreshold, comparatorPolarity, senseSelect} == $past(pwdata[7:2]))
        else $error("config fields not applied");
    chk_alert_drive: assert property (alertOe_b == !overcurrentTrip)
        else $error("alert pin does not follow trip");
    chk_temp_out: assert property (tempToCellOut == (cellOutputSelect == `OSEL_TEMP && cellIndex == `CELL_IDX_TEMP))
        else $error("temperature output select wrong");
    chk_bal_lock: assert property ((balanceSwitchOn & (balanceSwitchOn >> 1)) == 6'h00)
        else $error("adjacent switches both on");
    chk_bal_follow: assert property (wrAt(`ADDR_BALANCE_CONTROL_REG) |=> balanceSwitchOn == lock($past(pwdata[5:0])))
        else $error("balance switches wrong after write");
    chk_bias_en: assert property (wrAt(`ADDR_POWER_CONTROL_REG) |=> thermistorBiasEnable == $past(pwdata[`PWR_TB_BIT]))
        else $error("thermistor bias enable wrong");
    chk_status_alert: assert property (rdAt(`ADDR_STATUS) |=> prdata[`STATUS_ALERT_BIT] == $past(alertIn, 3))
        else $error("status alert bit does not follow pin");
    chk_unmapped_err: assert property (psel && penable && paddr > `ADDR_IRQ_MASK |-> pslverr)
        else $error("unmapped access not flagged");
endmodule
bind afe_current_temp_balance_control afe_ctrl_props u_afe_ctrl_props (.*);
`default_nettype wire

// ### afe_current_temp_balance_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_params.svh"
module afe_current_temp_balance_control_test;
    logic        clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, overcurrentTrip = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, senseSelect, ampInverting, comparatorPolarity, alertOut, alertOe_b, alertIn;
    logic        thermistorBiasEnable, tempToCellOut, irq, err;
    logic [3:0]  ampGain, overcurrentThreshold;
    logic [1:0]  zeroLevelNum, cellOutputSelect;
    logic [2:0]  zeroLevelDen, cellIndex;
    logic [5:0]  balanceSwitchOn;
    logic [5:0]  rows [5][2] = '{'{6'h15, 6'h15}, '{6'h03, 6'h00}, '{6'h0B, 6'h08}, '{6'h2D, 6'h21}, '{6'h3F, 6'h00}};
    int          bad_count = 0, check_count = 0;
    afe_current_temp_balance_control u_afe_current_temp_balance_control (.*);
    alert_pullup u_alert_pullup (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The master never assumes a latency; only the watchdog ends a stuck wait.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        @(negedge clk_sys);
    endtask
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int a = 4; a <= 24; a += 4) begin
            xfer(1'b0, a[11:0], 32'h0);
            cmp(rdat, 32'h0);
        end
        cmp({ampGain, balanceSwitchOn, irq}, {`GAIN_LOW, 7'h00});
        cmp({ampInverting, zeroLevelNum, zeroLevelDen}, {1'b1, `ZERO_LEVEL_NUM, `ZERO_LEVEL_DEN});
        foreach (rows[i]) begin
            xfer(1'b1, `ADDR_BALANCE_CONTROL_REG, {26'h0, rows[i][0]});
            cmp(balanceSwitchOn, rows[i][1]);
            xfer(1'b0, `ADDR_BALANCE_CONTROL_REG, 32'h0);
            cmp(rdat, rows[i][0]);
        end
        xfer(1'b1, `ADDR_CONFIG, 32'hFD);
        cmp({ampGain, overcurrentThreshold, comparatorPolarity, senseSelect}, {`GAIN_HIGH, 6'h3F});
        xfer(1'b1, `ADDR_CONFIG, 32'h00);
        cmp({ampGain, senseSelect}, {`GAIN_LOW, 1'b0});
        xfer(1'b1, `ADDR_CELL_CONTROL_REG, 32'h16);
        cmp(tempToCellOut, 1'b1);
        xfer(1'b1, `ADDR_CELL_CONTROL_REG, 32'h26);
        cmp(tempToCellOut, 1'b0);
        xfer(1'b1, `ADDR_POWER_CONTROL_REG, 32'h04);
        cmp(thermistorBiasEnable, 1'b1);
        xfer(1'b1, `ADDR_POWER_CONTROL_REG, 32'hFB);
        cmp(thermistorBiasEnable, 1'b0);
        xfer(1'b1, 12'h01C, 32'hFF);
        xfer(1'b0, 12'h01C, 32'h0);
        cmp({err, rdat}, {1'b1, 32'h0});
        @(posedge clk_sys);
        overcurrentTrip <= 1'b1;
        repeat (5) @(posedge clk_sys);
        cmp({alertOe_b, alertIn, irq}, 3'h0);
        xfer(1'b0, `ADDR_STATUS, 32'h0);
        cmp(rdat[2], 1'b0);
        xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        cmp(rdat, 32'h2);
        xfer(1'b1, `ADDR_IRQ_MASK, 32'h2);
        cmp(irq, 1'b1);
        xfer(1'b1, `ADDR_IRQ_STATUS, 32'h2);
        cmp(irq, 1'b0);
        overcurrentTrip <= 1'b0;
        repeat (5) @(posedge clk_sys);
        xfer(1'b0, `ADDR_STATUS, 32'h0);
        cmp(rdat[2], 1'b1);
        xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        cmp({rdat, irq}, {32'h1, 1'b0});
        xfer(1'b1, `ADDR_BALANCE_CONTROL_REG, 32'h01);
        xfer(1'b1, `ADDR_CONFIG, 32'h01);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        cmp({ampGain, balanceSwitchOn, irq}, {`GAIN_LOW, 7'h00});
        cmp(prdata, 32'h0);
        xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        cmp(rdat, 32'h0);
        xfer(1'b0, `ADDR_STATUS, 32'h0);
        cmp(rdat, 32'h4);
        tally_and_finish();
    end
endmodule
`default_nettype wire
